// *** include/plldc_defines.vh ***
`ifndef PLLDC_DEFINES_VH
`define PLLDC_DEFINES_VH

// ********************************************************************
// register offsets
// ********************************************************************
`define PLLDC_ADDR_W          8
`define PLLDC_OFF_REF_LOW     8'h54
`define PLLDC_OFF_OUT_REF     8'h55
`define PLLDC_OFF_PRE_LOW     8'h56
`define PLLDC_OFF_PRE_HIGH    8'h57
`define PLLDC_OFF_CP          8'h58
`define PLLDC_OFF_EN_ONE      8'h59
`define PLLDC_OFF_LF_RES      8'h5A
`define PLLDC_OFF_LF_C3       8'h5B
`define PLLDC_OFF_LF_C1       8'h5C
`define PLLDC_OFF_LF_C2       8'h5D
`define PLLDC_OFF_EN_TWO      8'h5F

// ********************************************************************
// reset values
// ********************************************************************
`define PLLDC_RST_REF_LOW     8'h00
`define PLLDC_RST_OUT_REF     8'h48
`define PLLDC_RST_PRE_LOW     8'h78
`define PLLDC_RST_PRE_HIGH    8'h40
`define PLLDC_RST_CP          8'h12
`define PLLDC_RST_EN_ONE      8'h41
`define PLLDC_RST_LF_RES      8'h2F
`define PLLDC_RST_LF_CAP      8'h27
`define PLLDC_RST_EN_TWO      8'hF1

// ********************************************************************
// field positions
// ********************************************************************
`define PLLDC_REF_HI_MSB      1
`define PLLDC_PRE_HI_MSB      3
`define PLLDC_CP_CODE_MSB     3
`define PLLDC_CP_BIAS_BIT     4
`define PLLDC_EN_REFDIV_BIT   4
`define PLLDC_EN_CORE_BIT     1
`define PLLDC_EN_OUT_BIT      3
`define PLLDC_EN_BIAS_BIT     2
`define PLLDC_LF_CODE_MSB     4
`define PLLDC_UNIMP_BIT       7
`define PLLDC_REF_UNSUP       10'h002

`endif

// *** verilog/plldc_divider.v ***
`timescale 1ns/100ps
`default_nettype none
`include "plldc_defines.vh"

// ********************************************************************
// programmable clock-enable divider: code 0 or 1, or HOLD_ONE high, passes
// every enabled edge, code n otherwise emits one pulse every n enabled edges
// ********************************************************************
module plldc_divider
#(
  parameter WIDTH = 12
)
(
  // clock and reset
  input  wire             CLK,
  input  wire             RST_N,
  input  wire             CE,
  // divider
  input  wire             IN_PULSE,
  input  wire             HOLD_ONE,
  input  wire [WIDTH-1:0] RATIO,
  output reg              OUT_PULSE
);

  reg  [WIDTH-1:0] count_q;
  wire             pass_through;
  wire             wrap;

  assign pass_through = HOLD_ONE || (RATIO <= {{(WIDTH-1){1'b0}}, 1'b1});
  // a ratio shrunk below the running count restarts with a pulse on the next enabled input pulse
  assign wrap = (count_q >= RATIO - {{(WIDTH-1){1'b0}}, 1'b1});

  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      count_q   <= {WIDTH{1'b0}};
      OUT_PULSE <= 1'b0;
    end
    else if (CE)
    begin
      if (!IN_PULSE)
      begin
        OUT_PULSE <= 1'b0;
      end
      else if (pass_through || wrap)
      begin
        count_q   <= {WIDTH{1'b0}};
        OUT_PULSE <= 1'b1;
      end
      else
      begin
        count_q   <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
        OUT_PULSE <= 1'b0;
      end
    end
  end

endmodule // plldc_divider

`default_nettype wire

// *** verilog/plldc_config.v ***
`timescale 1ns/100ps
`default_nettype none
`include "plldc_defines.vh"

// Behaviour
// (RL1) ref code 3..1023 divides by value
// (RL2) refdiv insert bit 4, default bypass
// (RL3) prescaler low 0x56, high 0x57 bits 3:0
// (RL4) prescaler divides by code, zero divides one
// (RL5) prescaler default 120
// (RL6) divided VCO feeds phase detector
// (RL7) charge-pump current code, default 0010
// (RL8) bias source bit 4, default self-bias
// (RL9) resistor code 5 bits, default 01111
// (RL10) cap three code, default 00111
// (RL11) cap one code, default 00111
// (RL12) cap two code, default 00111
// (RL13) software picks loop values by frequency
// (RL14) software keeps factory bits at default
// (RL15) bit 7 unimplemented, reads zero
// (RL16) ref divider 10 bits across two registers
// (RL17) output needs out, bias, core enables
// (RL18) dividers use concatenated stored fields
// (RL19) fields read back, reset to defaults
module plldc_config
(
  // clock and reset
  input  wire        CLK,
  input  wire        RST_N,
  input  wire        CE,
  // register port
  input  wire [7:0]  ADDR,
  input  wire [7:0]  WDATA,
  input  wire        WR,
  input  wire        RD,
  output reg  [7:0]  RDATA,
  // clocks as enable pulses, from synthesizer-side logic on CLK
  input  wire        REF_PULSE,
  input  wire        VCO_PULSE,
  output wire        PFD_REF_PULSE,
  output wire        PFD_FB_PULSE,
  // analog settings
  output wire [9:0]  REF_DIV_RATIO,
  output wire        REF_DIV_INSERT,
  output wire [11:0] FB_PRESCALE,
  output wire [3:0]  CP_CURRENT_CODE,
  output wire        CP_SELF_BIAS,
  output wire [4:0]  LOOP_FILTER_RES_CODE,
  output wire [4:0]  LOOP_FILTER_C1_CODE,
  output wire [4:0]  LOOP_FILTER_C2_CODE,
  output wire [4:0]  LOOP_FILTER_C3_CODE,
  output wire        CORE_ENABLE,
  output wire        SYNTH_OUT_ENABLE
);

  // ********************************************************************
  // register storage
  // ********************************************************************
  reg  [7:0] ref_low_q;
  reg  [7:0] out_ref_q;
  reg  [7:0] pre_low_q;
  reg  [7:0] pre_high_q;
  reg  [7:0] cp_q;
  reg  [7:0] en_one_q;
  reg  [7:0] lf_res_q;
  reg  [7:0] lf_c3_q;
  reg  [7:0] lf_c1_q;
  reg  [7:0] lf_c2_q;
  reg  [7:0] en_two_q;
  reg  [7:0] rdata_d;
  wire       ref_div_pulse;
  wire       ref_unsup;

  // bit 7 is masked off on the registers that do not implement it
  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ref_low_q  <= `PLLDC_RST_REF_LOW;  // RL19
      out_ref_q  <= `PLLDC_RST_OUT_REF;
      pre_low_q  <= `PLLDC_RST_PRE_LOW;  // RL5
      pre_high_q <= `PLLDC_RST_PRE_HIGH; // RL5
      cp_q       <= `PLLDC_RST_CP;       // RL7
      en_one_q   <= `PLLDC_RST_EN_ONE;   // RL2
      lf_res_q   <= `PLLDC_RST_LF_RES;   // RL9
      lf_c3_q    <= `PLLDC_RST_LF_CAP;   // RL10
      lf_c1_q    <= `PLLDC_RST_LF_CAP;   // RL11
      lf_c2_q    <= `PLLDC_RST_LF_CAP;   // RL12
      en_two_q   <= `PLLDC_RST_EN_TWO;
    end
    else if (CE && WR)
    begin
      case (ADDR)
        `PLLDC_OFF_REF_LOW:  ref_low_q  <= WDATA;
        `PLLDC_OFF_OUT_REF:  out_ref_q  <= WDATA;
        `PLLDC_OFF_PRE_LOW:  pre_low_q  <= WDATA;            // RL3
        `PLLDC_OFF_PRE_HIGH: pre_high_q <= WDATA;            // RL3
        `PLLDC_OFF_CP:       cp_q       <= WDATA;
        `PLLDC_OFF_EN_ONE:   en_one_q   <= {1'b0, WDATA[6:0]}; // RL15
        `PLLDC_OFF_LF_RES:   lf_res_q   <= {1'b0, WDATA[6:0]}; // RL15
        `PLLDC_OFF_LF_C3:    lf_c3_q    <= {1'b0, WDATA[6:0]}; // RL15
        `PLLDC_OFF_LF_C1:    lf_c1_q    <= {1'b0, WDATA[6:0]}; // RL15
        `PLLDC_OFF_LF_C2:    lf_c2_q    <= {1'b0, WDATA[6:0]}; // RL15
        `PLLDC_OFF_EN_TWO:   en_two_q   <= WDATA;
        default:             ref_low_q  <= ref_low_q;
      endcase
    end
  end

  // ********************************************************************
  // read path: data one cycle after the strobe, zero otherwise
  // ********************************************************************
  always @*
  begin
    case (ADDR)
      `PLLDC_OFF_REF_LOW:  rdata_d = ref_low_q;  // RL19
      `PLLDC_OFF_OUT_REF:  rdata_d = out_ref_q;
      `PLLDC_OFF_PRE_LOW:  rdata_d = pre_low_q;
      `PLLDC_OFF_PRE_HIGH: rdata_d = pre_high_q;
      `PLLDC_OFF_CP:       rdata_d = cp_q;
      `PLLDC_OFF_EN_ONE:   rdata_d = en_one_q;   // RL15
      `PLLDC_OFF_LF_RES:   rdata_d = lf_res_q;
      `PLLDC_OFF_LF_C3:    rdata_d = lf_c3_q;
      `PLLDC_OFF_LF_C1:    rdata_d = lf_c1_q;
      `PLLDC_OFF_LF_C2:    rdata_d = lf_c2_q;
      `PLLDC_OFF_EN_TWO:   rdata_d = en_two_q;
      default:             rdata_d = 8'h00;
    endcase
  end

  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      RDATA <= 8'h00;
    end
    else if (CE)
    begin
      RDATA <= RD ? rdata_d : 8'h00;
    end
  end

  // ********************************************************************
  // field decode
  // ********************************************************************
  // combined values track both stored halves live
  assign REF_DIV_RATIO  = {out_ref_q[`PLLDC_REF_HI_MSB:0], ref_low_q};   // RL16 RL18
  assign FB_PRESCALE    = {pre_high_q[`PLLDC_PRE_HI_MSB:0], pre_low_q}; // RL3 RL18
  assign REF_DIV_INSERT = en_one_q[`PLLDC_EN_REFDIV_BIT];               // RL2
  assign CP_CURRENT_CODE = cp_q[`PLLDC_CP_CODE_MSB:0];                  // RL7
  assign CP_SELF_BIAS   = cp_q[`PLLDC_CP_BIAS_BIT];                     // RL8
  assign LOOP_FILTER_RES_CODE = lf_res_q[`PLLDC_LF_CODE_MSB:0];         // RL9
  assign LOOP_FILTER_C3_CODE  = lf_c3_q[`PLLDC_LF_CODE_MSB:0];          // RL10
  assign LOOP_FILTER_C1_CODE  = lf_c1_q[`PLLDC_LF_CODE_MSB:0];          // RL11
  assign LOOP_FILTER_C2_CODE  = lf_c2_q[`PLLDC_LF_CODE_MSB:0];          // RL12
  assign CORE_ENABLE    = en_one_q[`PLLDC_EN_CORE_BIT];
  assign SYNTH_OUT_ENABLE = en_two_q[`PLLDC_EN_OUT_BIT] & en_two_q[`PLLDC_EN_BIAS_BIT]
                          & CORE_ENABLE; // RL17

  // ********************************************************************
  // dividers
  // ********************************************************************
  // code 2 is unsupported; it is treated as divide-by-one rather than
  // leaving the loop with an undefined reference
  assign ref_unsup = (REF_DIV_RATIO == `PLLDC_REF_UNSUP);

  plldc_divider #(.WIDTH(10)) u_ref_div
  (
    .CLK       (CLK),
    .RST_N     (RST_N),
    .CE        (CE),
    .IN_PULSE  (REF_PULSE),
    .HOLD_ONE  (ref_unsup),
    .RATIO     (REF_DIV_RATIO),   // RL1
    .OUT_PULSE (ref_div_pulse)
  );

  // with CORE_ENABLE high, bypass routes the raw reference straight to the detector
  assign PFD_REF_PULSE = (REF_DIV_INSERT ? ref_div_pulse : REF_PULSE) & CORE_ENABLE; // RL2

  plldc_divider #(.WIDTH(12)) u_fb_div
  (
    .CLK       (CLK),
    .RST_N     (RST_N),
    .CE        (CE),
    .IN_PULSE  (VCO_PULSE),
    .HOLD_ONE  (1'b0),
    .RATIO     (FB_PRESCALE),     // RL4
    .OUT_PULSE (PFD_FB_PULSE)     // RL6
  );

endmodule // plldc_config

`default_nettype wire

// *** verification/plldc_config_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
// ********************************************************************
// configuration port checker
// ********************************************************************
module plldc_chk
(
  // clock, reset and register port
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        CE,
  input wire logic [7:0]  ADDR,
  input wire logic [7:0]  WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [7:0]  RDATA,
  // pulses and settings
  input wire logic        REF_PULSE,
  input wire logic        VCO_PULSE,
  input wire logic        PFD_REF_PULSE,
  input wire logic        PFD_FB_PULSE,
  input wire logic        REF_DIV_INSERT,
  input wire logic [11:0] FB_PRESCALE,
  input wire logic [3:0]  CP_CURRENT_CODE,
  input wire logic        CP_SELF_BIAS,
  input wire logic [4:0]  LOOP_FILTER_RES_CODE,
  input wire logic        CORE_ENABLE,
  input wire logic        SYNTH_OUT_ENABLE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  a_pre_low: assert property (WR && CE && ADDR == 8'h56 |=> FB_PRESCALE[7:0] == $past(WDATA))
    else $error("prescale low byte not stored");
  a_pre_high: assert property (WR && CE && ADDR == 8'h57 |=> FB_PRESCALE[11:8] == $past(WDATA[3:0]))
    else $error("prescale high bits not stored");
  a_read_back: assert property (RD && CE && ADDR == 8'h56 |=> RDATA == FB_PRESCALE[7:0])
    else $error("prescale read back differs");
  a_cp_fields: assert property (WR && CE && ADDR == 8'h58 ##1 1 |-> {CP_SELF_BIAS, CP_CURRENT_CODE} == $past(WDATA[4:0]))
    else $error("charge pump fields not stored");
  a_refdiv_flag: assert property (WR && CE && ADDR == 8'h59 |=> REF_DIV_INSERT == $past(WDATA[4]))
    else $error("divider insert flag not stored");
  a_res_code: assert property (WR && CE && ADDR == 8'h5A |=> LOOP_FILTER_RES_CODE == $past(WDATA[4:0]))
    else $error("resistor code not stored");
  a_unimp_zero: assert property (RD && CE && ADDR >= 8'h59 && ADDR <= 8'h5D |=> !RDATA[7])
    else $error("unimplemented bit reads one");
  a_fb_bypass: assert property (CE && VCO_PULSE && FB_PRESCALE < 12'h002 |=> PFD_FB_PULSE)
    else $error("feedback pulse missing at ratio one");
  a_ref_bypass: assert property (CORE_ENABLE && !REF_DIV_INSERT |-> PFD_REF_PULSE == REF_PULSE)
    else $error("bypassed reference differs");
  a_out_gate: assert property (SYNTH_OUT_ENABLE |-> CORE_ENABLE)
    else $error("output enabled with core off");
  a_rdata_idle: assert property (CE && !RD |=> RDATA == 8'h00)
    else $error("read data not zero outside a read");
  c_fb: cover property (PFD_FB_PULSE);
  c_ref: cover property (REF_DIV_INSERT && PFD_REF_PULSE);
  c_out: cover property ($rose(SYNTH_OUT_ENABLE));
endmodule // plldc_chk

bind plldc_config plldc_chk chk_u
(
  .CLK                  (CLK),
  .RST_N                (RST_N),
  .CE                   (CE),
  .ADDR                 (ADDR),
  .WDATA                (WDATA),
  .WR                   (WR),
  .RD                   (RD),
  .RDATA                (RDATA),
  .REF_PULSE            (REF_PULSE),
  .VCO_PULSE            (VCO_PULSE),
  .PFD_REF_PULSE        (PFD_REF_PULSE),
  .PFD_FB_PULSE         (PFD_FB_PULSE),
  .REF_DIV_INSERT       (REF_DIV_INSERT),
  .FB_PRESCALE          (FB_PRESCALE),
  .CP_CURRENT_CODE      (CP_CURRENT_CODE),
  .CP_SELF_BIAS         (CP_SELF_BIAS),
  .LOOP_FILTER_RES_CODE (LOOP_FILTER_RES_CODE),
  .CORE_ENABLE          (CORE_ENABLE),
  .SYNTH_OUT_ENABLE     (SYNTH_OUT_ENABLE)
);
`default_nettype wire

// *** verification/plldc_config_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
// ********************************************************************
// stimulus and checks
// ********************************************************************
module plldc_config_tb;
  logic        CLK = 0, RST_N = 0, CE = 1, WR = 0, RD = 0, REF_PULSE = 0, VCO_PULSE = 0;
  logic [7:0]  ADDR = 8'h00, WDATA = 8'h00;
  wire  [7:0]  RDATA;
  wire  [9:0]  REF_DIV_RATIO;
  wire  [11:0] FB_PRESCALE;
  wire  [3:0]  CP_CURRENT_CODE;
  wire  [4:0]  LOOP_FILTER_RES_CODE, LOOP_FILTER_C1_CODE, LOOP_FILTER_C2_CODE, LOOP_FILTER_C3_CODE;
  wire         PFD_REF_PULSE, PFD_FB_PULSE, REF_DIV_INSERT, CP_SELF_BIAS, CORE_ENABLE;
  wire         SYNTH_OUT_ENABLE;
  int          err_total = 0, checks = 0;
  // offset in the high byte, power-on value in the low byte
  logic [15:0] dflt [11] = '{16'h5400, 16'h5548, 16'h5678, 16'h5740, 16'h5812, 16'h5941,
                             16'h5A2F, 16'h5B27, 16'h5C27, 16'h5D27, 16'h5FF1};
  plldc_config dut_u
  (
    .CLK                  (CLK),
    .RST_N                (RST_N),
    .CE                   (CE),
    .ADDR                 (ADDR),
    .WDATA                (WDATA),
    .WR                   (WR),
    .RD                   (RD),
    .RDATA                (RDATA),
    .REF_PULSE            (REF_PULSE),
    .VCO_PULSE            (VCO_PULSE),
    .PFD_REF_PULSE        (PFD_REF_PULSE),
    .PFD_FB_PULSE         (PFD_FB_PULSE),
    .REF_DIV_RATIO        (REF_DIV_RATIO),
    .REF_DIV_INSERT       (REF_DIV_INSERT),
    .FB_PRESCALE          (FB_PRESCALE),
    .CP_CURRENT_CODE      (CP_CURRENT_CODE),
    .CP_SELF_BIAS         (CP_SELF_BIAS),
    .LOOP_FILTER_RES_CODE (LOOP_FILTER_RES_CODE),
    .LOOP_FILTER_C1_CODE  (LOOP_FILTER_C1_CODE),
    .LOOP_FILTER_C2_CODE  (LOOP_FILTER_C2_CODE),
    .LOOP_FILTER_C3_CODE  (LOOP_FILTER_C3_CODE),
    .CORE_ENABLE          (CORE_ENABLE),
    .SYNTH_OUT_ENABLE     (SYNTH_OUT_ENABLE)
  );
  initial forever #25 CLK = ~CLK;
  task chk(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    // let the stored value settle before any caller looks at it
    @(negedge CLK);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    @(negedge CLK);
    chk({4'h0, RDATA}, {4'h0, e});
  endtask
  // a pulse every cycle is the densest input, so count phase slips show up
  task cnt(input logic fb, input int n, input logic [11:0] e);
    logic [11:0] c;
    c = 12'h000;
    for (int i = 0; i < n + 3; i++)
    begin
      @(posedge CLK);
      VCO_PULSE <= fb && (i < n);
      REF_PULSE <= !fb && (i < n);
      @(negedge CLK);
      c = c + {11'h000, (fb ? PFD_FB_PULSE : PFD_REF_PULSE)};
    end
    chk(c, e);
  endtask
  task t_reset;
    foreach (dflt[i]) rd(dflt[i][15:8], dflt[i][7:0]);
    rd(8'h60, 8'h00);
    chk(FB_PRESCALE, 12'h078);
    chk({7'h00, CP_SELF_BIAS, CP_CURRENT_CODE}, 12'h012);
    chk({2'h0, LOOP_FILTER_C3_CODE, LOOP_FILTER_C1_CODE}, 12'h0E7);
    chk({2'h0, LOOP_FILTER_C2_CODE, LOOP_FILTER_RES_CODE}, 12'h0EF);
    chk({9'h000, REF_DIV_INSERT, CORE_ENABLE, SYNTH_OUT_ENABLE}, 12'h000);
  endtask
  task t_regs;
    for (int i = 5; i < 10; i++) wr(dflt[i][15:8], dflt[i][7:0] | 8'h80);
    for (int i = 5; i < 10; i++) rd(dflt[i][15:8], dflt[i][7:0]);
    wr(8'h58, 8'h0F);
    wr(8'h5A, 8'h3F);
    wr(8'h5B, 8'h33);
    wr(8'h5C, 8'h31);
    wr(8'h5D, 8'h32);
    chk({7'h00, CP_SELF_BIAS, CP_CURRENT_CODE}, 12'h00F);
    chk({2'h0, LOOP_FILTER_C3_CODE, LOOP_FILTER_RES_CODE}, 12'h27F);
    chk({2'h0, LOOP_FILTER_C2_CODE, LOOP_FILTER_C1_CODE}, 12'h251);
    rd(8'h5A, 8'h3F);
  endtask
  task t_fb;
    wr(8'h56, 8'h03);
    cnt(1'b1, 12, 12'd4);
    wr(8'h56, 8'h00);
    cnt(1'b1, 12, 12'd12);
    wr(8'h57, 8'h4F);
    wr(8'h56, 8'hFF);
    chk(FB_PRESCALE, 12'hFFF);
  endtask
  task t_ref;
    wr(8'h59, 8'h53);
    wr(8'h54, 8'h03);
    cnt(1'b0, 12, 12'd4);
    wr(8'h54, 8'h00);
    cnt(1'b0, 12, 12'd12);
    wr(8'h54, 8'h01);
    cnt(1'b0, 12, 12'd12);
    wr(8'h54, 8'h02);
    cnt(1'b0, 12, 12'd12);
    wr(8'h55, 8'h4B);
    wr(8'h54, 8'hFF);
    chk({2'h0, REF_DIV_RATIO}, 12'h3FF);
    wr(8'h59, 8'h43);
    cnt(1'b0, 5, 12'd5);
    wr(8'h5F, 8'hFD);
    chk({11'h000, SYNTH_OUT_ENABLE}, 12'h001);
  endtask
  // a write taken while the clock enable is low must leave no trace
  task t_freeze;
    @(posedge CLK);
    CE <= 1'b0;
    wr(8'h56, 8'h55);
    @(posedge CLK);
    CE <= 1'b1;
    @(negedge CLK);
    chk(FB_PRESCALE, 12'hFFF);
  endtask
  // a reset in mid-run must bring every written field back to default
  task t_rerun;
    @(posedge CLK);
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    t_reset;
  endtask
  task report_and_stop;
    $display("mismatches %0d comparisons %0d", err_total, checks);
    if (err_total == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge CLK);
    RST_N <= 1'b1;
    t_reset;
    t_regs;
    t_fb;
    t_ref;
    t_freeze;
    t_rerun;
    report_and_stop;
  end
endmodule // plldc_config_tb
`default_nettype wire
